// ### core/adc_seq_pkg.sv
/*
 * Constants for the conversion sequence control block: register offsets,
 * field positions, reset values and event bit positions.
 * Assumes a 32-bit Avalon-MM bus with byte addresses, one word per register.
 */
package adc_seq_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    localparam logic [3:0]  OFF_CTRL      = 4'h0;
    localparam logic [3:0]  OFF_STATUS    = 4'h4;
    localparam logic [3:0]  OFF_MASK      = 4'h8;
    localparam logic [3:0]  OFF_STATE     = 4'hC;
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [15:0] CTRL_WMASK    = 16'h073F;
    localparam int          SCAN_BIT      = 10;
    localparam int          CHCNT_LO      = 8;
    localparam int          HALF_BIT      = 7;
    localparam int          RATE_LO       = 2;
    localparam int          SPLIT_BIT     = 1;
    localparam int          ALT_BIT       = 0;
    localparam int          NEV           = 2;
    localparam int          EV_RATE       = 0;
    localparam int          EV_HALF       = 1;
    localparam logic [1:0]  EV_RST        = 2'h0;
    localparam logic [3:0]  CHEN_ALL      = 4'hF;
    localparam logic [3:0]  CHEN_PAIR     = 4'h3;
    localparam logic [3:0]  CHEN_ONE      = 4'h1;
    localparam logic [3:0]  SCAN_RST      = 4'h0;
    localparam logic [3:0]  COUNT_RST     = 4'h0;
endpackage : adc_seq_pkg

// ### core/seq_if.sv
/*
 * Carrier between the control block and its rate counter.
 * Assumes both ends share i_clk.
 */
`timescale 1ns/100ps
interface seq_if;
    logic [3:0] rate;
    logic       split;
    logic       done;
    logic [3:0] count;
    logic       tick;
    logic       half;
    modport ctrl (output rate, output split, output done,
                  input count, input tick, input half);
    modport cnt  (input rate, input split, input done,
                  output count, output tick, output half);
endinterface : seq_if

// ### core/rate_seq.sv
/*
 * Sample/conversion rate counter and buffer half tracker.
 * Assumes done is a one-cycle pulse on i_clk per completed operation.
 */
`timescale 1ns/100ps
module rate_seq
    import adc_seq_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    seq_if.cnt        s
);
    logic [3:0] count_q, count_d;
    logic       half_q,  half_d;

    // tick after rate+1 completed operations
    assign s.tick  = s.done && (count_q == s.rate);
    assign s.count = count_q;
    assign s.half  = half_q;

    always_comb begin
        count_d = count_q;
        half_d  = half_q;
        if (s.done) begin
            count_d = s.tick ? COUNT_RST : count_q + 4'h1;
        end
        // split mode flips halves per interrupt, else always first half
        if (!s.split) begin
            half_d = 1'b0;
        end else if (s.tick) begin
            half_d = ~half_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_q <= COUNT_RST;
            half_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            half_q  <= half_d;
        end
    end

    a_rate_period: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s.tick |-> s.done && count_q == s.rate
        ##1 s.count == COUNT_RST)
        else $error("tick not at rate plus one operations");
    a_half_flip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s.tick && s.split) |=> s.half != $past(s.half))
        else $error("buffer half did not flip on tick");
endmodule : rate_seq

// ### core/adc_seq_ctrl.sv
/*
 * Conversion sequence control register with its sequencing logic:
 * channel selection, scan stepping, alternate sampling, rate ticks,
 * split buffer filling, event status/mask and a level interrupt.
 * Assumes an Avalon-MM master on i_clk and a converter front end that
 * pulses i_conv_done once per completed sample/conversion operation.
 */
// Overview of operation
// - scan enable steps channel zero positive input over selected inputs in sample A
// - in twelve-bit mode channel count ignores writes and reads zero
// - channel count: upper bit all four, 01 two, 00 channel zero only
// - split mode fills halves alternately per interrupt; else restart at buffer start
// - alternate mode swaps sample A and B selections each sample; else A only
`timescale 1ns/100ps
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [DATA_W-1:0] i_writedata,
    input  wire logic [3:0]        i_byteenable,
    output logic      [DATA_W-1:0] o_readdata,
    output logic                   o_waitrequest,
    input  wire logic              i_twelve_bit_mode,
    input  wire logic              i_conv_done,
    input  wire logic [15:0]       i_scan_inputs,
    output logic                   o_scan_active,
    output logic      [3:0]        o_ch0_pos_sel,
    output logic      [3:0]        o_chan_enable,
    output logic                   o_use_sample_b,
    output logic                   o_buffer_half_status,
    output logic      [4:0]        o_buf_slot,
    output logic                   o_rate_tick,
    output logic                   o_irq
);
    ////////////////////////////////////////////////////////////////////
    // decoders

    function automatic logic [3:0] chan_map(input logic [1:0] code);
        if (code[1]) begin
            chan_map = CHEN_ALL;
        end else if (code[0]) begin
            chan_map = CHEN_PAIR;
        end else begin
            chan_map = CHEN_ONE;
        end
    endfunction : chan_map

    // next set bit after cur, wrapping; cur kept if mask empty
    function automatic logic [3:0] next_scan(input logic [15:0] m,
                                             input logic [3:0]  cur);
        logic [3:0] idx;
        logic       hit;
        next_scan = cur;
        hit       = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            idx = cur + 4'(i);
            if (!hit && m[idx]) begin
                next_scan = idx;
                hit       = 1'b1;
            end
        end
    endfunction : next_scan

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle per access

    logic              ack_q, ack_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              req;
    logic              wr_go;

    assign req           = i_read || i_write;
    assign o_waitrequest = req && !ack_q;
    assign wr_go         = i_write && ack_q;
    assign o_readdata    = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [15:0]     ctrl_q, ctrl_d;
    logic [NEV-1:0]  stat_q, stat_d;
    logic [NEV-1:0]  mask_q, mask_d;
    logic [NEV-1:0]  ev;
    logic [1:0]      chcnt_eff;
    logic [15:0]     ctrl_rd;
    logic [15:0]     wmask;
    logic [3:0]      scan_q, scan_d;
    logic            samp_b_q, samp_b_d;

    seq_if s();

    // hidden while twelve-bit mode is on; stored bits kept for later
    assign chcnt_eff = i_twelve_bit_mode ? 2'h0
                     : ctrl_q[CHCNT_LO +: 2];

    always_comb begin
        ctrl_rd                = ctrl_q & CTRL_WMASK;
        ctrl_rd[CHCNT_LO +: 2] = chcnt_eff;
        ctrl_rd[HALF_BIT]      = s.half;
    end

    always_comb begin
        wmask = CTRL_WMASK & {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
        if (i_twelve_bit_mode) begin
            wmask[CHCNT_LO +: 2] = 2'h0;
        end
    end

    assign ev = {s.tick && s.split, s.tick};

    always_comb begin
        ack_d   = req && !ack_q;
        rdata_d = rdata_q;
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        if (req && !ack_q && i_read) begin
            case (i_address)
                OFF_CTRL:   rdata_d = {16'h0000, ctrl_rd};
                OFF_STATUS: rdata_d = {{(DATA_W-NEV){1'b0}}, stat_q};
                OFF_MASK:   rdata_d = {{(DATA_W-NEV){1'b0}}, mask_q};
                OFF_STATE:  rdata_d = {23'h000000, scan_q, samp_b_q,
                                       s.count};
                default:    rdata_d = 32'h00000000;
            endcase
        end
        if (wr_go && i_byteenable[0]) begin
            case (i_address)
                OFF_STATUS: stat_d = stat_q & ~i_writedata[NEV-1:0];
                OFF_MASK:   mask_d = i_writedata[NEV-1:0];
                default:    ;
            endcase
        end
        if (wr_go && i_address == OFF_CTRL) begin
            ctrl_d = (ctrl_q & ~wmask) | (i_writedata[15:0] & wmask);
        end
        // a new event wins over a same-cycle clear
        stat_d = stat_d | ev;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
            ctrl_q  <= CTRL_RST;
            stat_q  <= EV_RST;
            mask_q  <= EV_RST;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
        end
    end

    assign o_irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////
    // sequencing

    logic [3:0] chen_q, chen_d;
    logic       scan_en;
    logic       alt_en;

    assign scan_en = ctrl_q[SCAN_BIT];
    assign alt_en  = ctrl_q[ALT_BIT];

    assign s.rate  = ctrl_q[RATE_LO +: 4];
    assign s.split = ctrl_q[SPLIT_BIT];
    assign s.done  = i_conv_done;

    rate_seq u_rate (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .s         (s)
    );

    always_comb begin
        scan_d   = scan_q;
        samp_b_d = samp_b_q;
        chen_d   = chan_map(chcnt_eff);
        // only sample A conversions move the scan pointer
        if (scan_en && i_conv_done && !samp_b_q) begin
            scan_d = next_scan(i_scan_inputs, scan_q);
        end
        if (!alt_en) begin
            samp_b_d = 1'b0;
        end else if (i_conv_done) begin
            samp_b_d = ~samp_b_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scan_q   <= SCAN_RST;
            samp_b_q <= 1'b0;
            chen_q   <= CHEN_ONE;
        end else begin
            scan_q   <= scan_d;
            samp_b_q <= samp_b_d;
            chen_q   <= chen_d;
        end
    end

    assign o_scan_active        = scan_en && !samp_b_q;
    assign o_ch0_pos_sel        = scan_q;
    assign o_chan_enable        = chen_q;
    assign o_use_sample_b       = samp_b_q;
    assign o_buffer_half_status = s.half;
    // non-split fills always restart at slot zero after each tick
    assign o_buf_slot           = {s.half, s.count};
    assign o_rate_tick          = s.tick;

    ////////////////////////////////////////////////////////////////////
    // checks

    a_scan_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !scan_en |=> $stable(scan_q))
        else $error("scan pointer moved while scanning is off");

    a_scan_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (scan_en && i_conv_done && !samp_b_q && i_scan_inputs != 16'h0000
         && $stable(i_scan_inputs)) |=> i_scan_inputs[scan_q]
        || !$stable(i_scan_inputs))
        else $error("scan pointer not on a selected input");

    a_twelve_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_read && !ack_q && i_address == OFF_CTRL && i_twelve_bit_mode)
        |=> o_readdata[CHCNT_LO +: 2] == 2'h0)
        else $error("channel count visible in twelve-bit mode");

    a_twelve_chan: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_twelve_bit_mode ##1 i_twelve_bit_mode
        |-> o_chan_enable == CHEN_ONE)
        else $error("extra channels enabled in twelve-bit mode");

    a_chan_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_twelve_bit_mode && $stable(ctrl_q)) |=>
        o_chan_enable == ($past(ctrl_q[CHCNT_LO + 1]) ? CHEN_ALL
        : $past(ctrl_q[CHCNT_LO]) ? CHEN_PAIR : CHEN_ONE))
        else $error("channel enables do not match channel count");

    a_split_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !s.split ##1 !s.split |-> !o_buf_slot[4])
        else $error("second half used without split mode");

    a_alt_swap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (alt_en && i_conv_done) |=> samp_b_q != $past(samp_b_q))
        else $error("sample selection did not alternate");

    a_alt_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !alt_en |=> !samp_b_q)
        else $error("sample B used without alternate mode");

    a_irq_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s.tick && mask_q[EV_RATE] && !(wr_go && i_address == OFF_MASK))
        |=> o_irq)
        else $error("rate tick did not raise the interrupt");
endmodule : adc_seq_ctrl

// ### testbench/testbench.sv
/*
 * Self-checking bench for the conversion sequence control block.
 * Assumes adc_seq_pkg and the core files are compiled first.
 */
`timescale 1ns/100ps
module testbench;
    import adc_seq_pkg::*;
    logic                i_clk;
    logic                i_sys_rst;
    logic [ADDR_W-1:0]   i_address;
    logic                i_read;
    logic                i_write;
    logic [DATA_W-1:0]   i_writedata;
    logic [3:0]          i_byteenable;
    logic [DATA_W-1:0]   o_readdata;
    logic                o_waitrequest;
    logic                i_twelve_bit_mode;
    logic                i_conv_done;
    logic [15:0]         i_scan_inputs;
    logic                o_scan_active;
    logic [3:0]          o_ch0_pos_sel;
    logic [3:0]          o_chan_enable;
    logic                o_use_sample_b;
    logic                o_buffer_half_status;
    logic [4:0]          o_buf_slot;
    logic                o_rate_tick;
    logic                o_irq;
    int                  err_total;
    int                  compares;
    int                  seed;
    logic [31:0]         rd;
    logic                tk;

    adc_seq_ctrl dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_twelve_bit_mode(i_twelve_bit_mode), .i_conv_done(i_conv_done),
        .i_scan_inputs(i_scan_inputs), .o_scan_active(o_scan_active),
        .o_ch0_pos_sel(o_ch0_pos_sel), .o_chan_enable(o_chan_enable),
        .o_use_sample_b(o_use_sample_b),
        .o_buffer_half_status(o_buffer_half_status),
        .o_buf_slot(o_buf_slot), .o_rate_tick(o_rate_tick), .o_irq(o_irq));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // request held until waitrequest is seen low before the edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
             output logic [31:0] rdat);
        int n;
        @(posedge i_clk);
        i_address   <= a;
        i_writedata <= wd;
        i_write     <= wr;
        i_read      <= !wr;
        n = 0;
        @(negedge i_clk);
        while (o_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                give_verdict();
            end
            @(negedge i_clk);
        end
        @(posedge i_clk);
        rdat = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    task rst;
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
    endtask : rst

    // one operation; tick sampled while the pulse is high
    task conv1(output logic t);
        @(posedge i_clk);
        i_conv_done <= 1'b1;
        @(negedge i_clk);
        t = o_rate_tick;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
        @(negedge i_clk);
    endtask : conv1

    function automatic logic [3:0] next_in(input logic [15:0] m,
                                           input logic [3:0] cur);
        for (int i = 1; i <= 16; i++)
            if (m[(cur + i) % 16]) return 4'((cur + i) % 16);
        return cur;
    endfunction : next_in

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0]  n;
        logic        sp;
        logic [1:0]  mk;
        logic [3:0]  p;
        logic        b;
        logic [15:0] m;
        logic [3:0]  chen [4];
        err_total = 0;
        compares = 0;
        seed = 51022;
        chen = '{4'h1, 4'h3, 4'hF, 4'hF};
        i_address = 4'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_byteenable = 4'hF;
        i_twelve_bit_mode = 1'b0;
        i_conv_done = 1'b0;
        i_scan_inputs = 16'h0;
        rst();
        bus(1'b0, OFF_CTRL, 32'h0, rd);
        chk("ctrl_reset", 32'h0, rd);
        chk("chen_reset", 32'h1, 32'(o_chan_enable));
        bus(1'b1, OFF_CTRL, 32'hFFFF_FFFF, rd);
        bus(1'b0, OFF_CTRL, 32'h0, rd);
        chk("ctrl_rw", 32'h0000_073F, rd);
        bus(1'b0, 4'h1, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, OFF_CTRL, 32'(c) << CHCNT_LO, rd);
            // enables are registered one edge after the write lands
            repeat (2) @(negedge i_clk);
            chk("chen", 32'(chen[c]), 32'(o_chan_enable));
        end
        @(posedge i_clk);
        i_twelve_bit_mode <= 1'b1;
        bus(1'b1, OFF_CTRL, 32'h0, rd);
        bus(1'b0, OFF_CTRL, 32'h0, rd);
        chk("chcnt_12b", 32'h0, rd);
        chk("chen_12b", 32'h1, 32'(o_chan_enable));
        i_twelve_bit_mode <= 1'b0;
        repeat (2) @(negedge i_clk);
        chk("chen_kept", 32'hF, 32'(o_chan_enable));
        for (int t = 0; t < 5; t++) begin
            n = (t == 0) ? 4'h0 : (t == 1) ? 4'hF : 4'($random(seed));
            sp = 1'($random(seed));
            mk = 2'($random(seed));
            @(posedge i_clk);
            rst();
            bus(1'b1, OFF_CTRL, 32'({n, sp, 1'b0}), rd);
            bus(1'b1, OFF_MASK, 32'(mk), rd);
            for (int r = 0; r < 2; r++)
                for (int k = 0; k <= n; k++) begin
                    conv1(tk);
                    chk("tick", 32'(k == n), 32'(tk));
                    if (k < n)
                        chk("slot", 32'({r[0] & sp, 4'(k + 1)}),
                            32'(o_buf_slot));
                    else chk("slot_wrap", 32'({(r == 0) & sp, 4'h0}),
                             32'(o_buf_slot));
                    if (k == n) chk("half", 32'((r == 0) & sp),
                                   32'(o_buffer_half_status));
                end
            bus(1'b0, OFF_STATUS, 32'h0, rd);
            chk("status", 32'({sp, 1'b1}), rd);
            chk("irq", 32'(|({sp, 1'b1} & mk)), 32'(o_irq));
            bus(1'b1, OFF_STATUS, 32'h3, rd);
            @(negedge i_clk);
            chk("irq_clr", 32'h0, 32'(o_irq));
        end
        @(posedge i_clk);
        rst();
        m = 16'($random(seed)) | 16'h0101;
        i_scan_inputs <= m;
        bus(1'b1, OFF_CTRL, 32'h0401, rd);
        p = 4'h0;
        b = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(negedge i_clk);
            chk("sample_b", 32'(b), 32'(o_use_sample_b));
            chk("scan_act", 32'(!b), 32'(o_scan_active));
            chk("ch0_sel", 32'(p), 32'(o_ch0_pos_sel));
            conv1(tk);
            if (!b) p = next_in(m, p);
            b = ~b;
        end
        bus(1'b1, OFF_CTRL, 32'h0, rd);
        conv1(tk);
        conv1(tk);
        chk("no_scan", 32'h0, 32'(o_scan_active));
        chk("held_sel", 32'(p), 32'(o_ch0_pos_sel));
        chk("alt_off", 32'h0, 32'(o_use_sample_b));
        give_verdict();
    end
endmodule : testbench
